// ### esmb_params.svh
// Purpose: Constants for the event status and mask register block
// Assumes: 32-bit register words, byte addressing
// Notes:   Offsets are byte addresses on the register bus
`ifndef ESMB_PARAMS_SVH
`define ESMB_PARAMS_SVH

`define ESMB_ADDR_W          4
`define ESMB_OFF_STATUS      4'h0
`define ESMB_OFF_CTRL        4'h4
`define ESMB_OFF_IRQ_STAT    4'h8
`define ESMB_OFF_IRQ_MASK    4'hC

`define ESMB_BIT_MISSED_FRAME_OVERFLOW_FLAG        9
`define ESMB_BIT_MISSED_FRAME_OVERFLOW_MASK       8
`define ESMB_BIT_RCVCO       5
`define ESMB_BIT_RCVCOM      4
`define ESMB_BIT_TXS         3
`define ESMB_BIT_TXSM        2
`define ESMB_BIT_JAB         1
`define ESMB_BIT_JABBER_ERROR_MASK        0

`define ESMB_CTRL_GLOBAL_INTERRUPT_ENABLE       0
`define ESMB_CTRL_STOP       1
`define ESMB_CTRL_SRESET     2
`define ESMB_CTRL_STYLE_LSB  8
`define ESMB_CTRL_STYLE_W    8

`define ESMB_STYLE_LEGACY    8'h01
`define ESMB_UNMAPPED_DATA   32'h0000_0000
`define ESMB_NUM_EVT         4

`endif

// ### esmb_pkg.sv
// Purpose: Types for the event status and mask register block
// Assumes: Used with esmb_params.svh
// Notes:   Types only
package esmb_pkg;
    typedef enum logic [1:0] {
        ESMB_IDLE = 2'b00,
        ESMB_RESP = 2'b01
    } esmb_state_t;
endpackage : esmb_pkg

// ### esmb_top.sv
// Purpose: Sticky event flags with masks and two interrupt outputs
// Assumes: Avalon-MM slave with waitrequest, synchronous active-high reset
// Notes:   Event inputs are one-cycle pulses in the SYS_CLK domain
//
// Overview of operation
// - Missed-frame wrap sets flag; W1C, reset, stop clear
// - Missed-frame flag interrupts when enabled and unmasked
// - Missed-frame mask blocks it; resets to one
// - Legacy style never sets missed-frame flag
// - Legacy style forces missed-frame mask to zero
// - Bit 7 reserved, reads zero
// - Bit 6 writable, reads zero, no effect
// - Rx collision wrap sets flag outside legacy style; W1C, reset, stop clear
// - Rx collision flag interrupts when enabled, unmasked
// - Rx collision mask blocks it; resets to one
// - Transmit start sets transmit start flag
// - Transmit start flag interrupts when enabled, unmasked
// - Transmit start flag: W1C, reset, stop clear
// - Transmit start mask read/write, resets to one
// - Jabber sets flag only in twisted-pair mode and outside legacy style
// - Jabber flag interrupts when enabled, unmasked
// - Jabber flag: W1C, reset, stop clear
// - Jabber mask read/write, resets to one
`timescale 1ns/1ps
`include "esmb_params.svh"

module esmb_top
    import esmb_pkg::*;
(
    input  wire logic                    SYS_CLK,
    input  wire logic                    RST,
    input  wire logic [`ESMB_ADDR_W-1:0] AVS_ADDRESS,
    input  wire logic                    AVS_READ,
    input  wire logic                    AVS_WRITE,
    input  wire logic [31:0]             AVS_WRITEDATA,
    input  wire logic [3:0]              AVS_BYTEENABLE,
    output logic      [31:0]             AVS_READDATA,
    output logic                         AVS_WAITREQUEST,
    input  wire logic                    MISSED_FRAME_WRAP,
    input  wire logic                    RX_COLLISION_WRAP,
    input  wire logic                    TX_FRAME_START,
    input  wire logic                    JABBER_DETECT,
    input  wire logic                    TP_PORT_ACTIVE,
    output logic                         INTERRUPT_OUTPUT,
    output logic                         BLOCK_IRQ
);

    ////////////////////////////////////////////////////////////////////////////
    // Bus handshake: one wait cycle, then answer

    esmb_state_t               state_reg;
    logic                      access;
    logic                      wr_ack;
    logic [31:0]               rd_data;

    assign access = (AVS_READ || AVS_WRITE) && state_reg == ESMB_IDLE;
    assign wr_ack = AVS_WRITE && state_reg == ESMB_RESP;

    always_ff @(posedge SYS_CLK) begin
        if (RST) begin
            state_reg <= ESMB_IDLE;
        end else begin
            case (state_reg)
                ESMB_IDLE: begin
                    if (AVS_READ || AVS_WRITE) begin
                        state_reg <= ESMB_RESP;
                    end
                end
                ESMB_RESP: state_reg <= ESMB_IDLE;
                default:   state_reg <= ESMB_IDLE;
            endcase
        end
    end

    // Waitrequest low from the edge that samples the request until the answer edge
    always_ff @(posedge SYS_CLK) begin
        if (RST) begin
            AVS_WAITREQUEST <= 1'b1;
        end else begin
            AVS_WAITREQUEST <= !access;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Control: enable, stop, software reset, style

    logic                            global_interrupt_enable_reg;
    logic                            stop_reg;
    logic                            sreset;
    logic [`ESMB_CTRL_STYLE_W-1:0]   style_reg;
    logic                            legacy;
    logic                            ctrl_wr;
    logic                            stat_wr;
    logic                            irqs_wr;
    logic                            irqm_wr;

    assign ctrl_wr = wr_ack && AVS_ADDRESS == `ESMB_OFF_CTRL;
    assign stat_wr = wr_ack && AVS_ADDRESS == `ESMB_OFF_STATUS;
    assign irqs_wr = wr_ack && AVS_ADDRESS == `ESMB_OFF_IRQ_STAT;
    assign irqm_wr = wr_ack && AVS_ADDRESS == `ESMB_OFF_IRQ_MASK;
    // Self-clearing pulse, so it never needs its own register
    assign sreset  = ctrl_wr && AVS_BYTEENABLE[0] && AVS_WRITEDATA[`ESMB_CTRL_SRESET];
    assign legacy  = style_reg == `ESMB_STYLE_LEGACY;

    always_ff @(posedge SYS_CLK) begin
        if (RST) begin
            global_interrupt_enable_reg  <= 1'b0;
            stop_reg  <= 1'b1;
            style_reg <= '0;
        end else if (ctrl_wr) begin
            if (AVS_BYTEENABLE[0]) begin
                global_interrupt_enable_reg <= AVS_WRITEDATA[`ESMB_CTRL_GLOBAL_INTERRUPT_ENABLE];
                stop_reg <= AVS_WRITEDATA[`ESMB_CTRL_STOP] | sreset;
            end
            if (AVS_BYTEENABLE[1]) begin
                style_reg <= AVS_WRITEDATA[`ESMB_CTRL_STYLE_LSB +: `ESMB_CTRL_STYLE_W];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Flags and masks; index 3 missed frame, 2 rx coll, 1 tx start, 0 jabber

    localparam int FLAG_POS [`ESMB_NUM_EVT] = '{`ESMB_BIT_JAB, `ESMB_BIT_TXS,
                                                `ESMB_BIT_RCVCO, `ESMB_BIT_MISSED_FRAME_OVERFLOW_FLAG};
    localparam int MASK_POS [`ESMB_NUM_EVT] = '{`ESMB_BIT_JABBER_ERROR_MASK, `ESMB_BIT_TXSM,
                                                `ESMB_BIT_RCVCOM, `ESMB_BIT_MISSED_FRAME_OVERFLOW_MASK};

    logic [`ESMB_NUM_EVT-1:0] flag_reg;
    logic [`ESMB_NUM_EVT-1:0] mask_reg;
    logic [`ESMB_NUM_EVT-1:0] mask_eff;
    logic [`ESMB_NUM_EVT-1:0] evt_set;
    logic [`ESMB_NUM_EVT-1:0] evt_clr;
    logic [`ESMB_NUM_EVT-1:0] evt_pulse;
    logic [15:0]              wlow;
    logic [1:0]               wlow_en;

    assign wlow    = AVS_WRITEDATA[15:0];
    assign wlow_en = AVS_BYTEENABLE[1:0];

    assign evt_pulse[3] = MISSED_FRAME_WRAP && !legacy;
    assign evt_pulse[2] = RX_COLLISION_WRAP && !legacy;
    assign evt_pulse[1] = TX_FRAME_START;
    // Jabber only from the twisted-pair port
    assign evt_pulse[0] = JABBER_DETECT && TP_PORT_ACTIVE && !legacy;

    genvar g;
    generate
        for (g = 0; g < `ESMB_NUM_EVT; g++) begin : g_evt
            localparam int FP = FLAG_POS[g];
            localparam int MP = MASK_POS[g];
            assign evt_set[g] = evt_pulse[g];
            assign evt_clr[g] = stat_wr && wlow_en[FP/8] && wlow[FP];
            // Set wins over clear; stop and resets clear
            always_ff @(posedge SYS_CLK) begin
                if (RST || sreset || stop_reg) begin
                    flag_reg[g] <= 1'b0;
                end else if (evt_set[g]) begin
                    flag_reg[g] <= 1'b1;
                end else if (evt_clr[g]) begin
                    flag_reg[g] <= 1'b0;
                end
            end
            // Masks ignore stop
            always_ff @(posedge SYS_CLK) begin
                if (RST || sreset) begin
                    mask_reg[g] <= 1'b1;
                end else if (stat_wr && wlow_en[MP/8]) begin
                    mask_reg[g] <= wlow[MP];
                end
            end
        end
    endgenerate

    // Legacy style forces the missed-frame mask to zero
    assign mask_eff = {mask_reg[3] && !legacy, mask_reg[2:0]};

    ////////////////////////////////////////////////////////////////////////////
    // Block's own interrupt status and mask

    logic [`ESMB_NUM_EVT-1:0] irq_stat_reg;
    logic [`ESMB_NUM_EVT-1:0] irq_mask_reg;

    always_ff @(posedge SYS_CLK) begin
        if (RST) begin
            irq_stat_reg <= '0;
        end else begin
            irq_stat_reg <= evt_set |
                            (irq_stat_reg & ~(irqs_wr ? AVS_WRITEDATA[`ESMB_NUM_EVT-1:0] : '0));
        end
    end

    always_ff @(posedge SYS_CLK) begin
        if (RST) begin
            irq_mask_reg <= '0;
        end else if (irqm_wr) begin
            irq_mask_reg <= AVS_WRITEDATA[`ESMB_NUM_EVT-1:0];
        end
    end

    always_ff @(posedge SYS_CLK) begin
        if (RST) begin
            BLOCK_IRQ <= 1'b0;
        end else begin
            BLOCK_IRQ <= |(irq_stat_reg & irq_mask_reg);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Interrupt output, one cycle behind the flags

    always_ff @(posedge SYS_CLK) begin
        if (RST) begin
            INTERRUPT_OUTPUT <= 1'b0;
        end else begin
            INTERRUPT_OUTPUT <= global_interrupt_enable_reg && |(flag_reg & ~mask_eff);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Read data; bits 7 and 6 always read zero

    always_comb begin
        rd_data = `ESMB_UNMAPPED_DATA;
        case (AVS_ADDRESS)
            `ESMB_OFF_STATUS: begin
                rd_data[`ESMB_BIT_MISSED_FRAME_OVERFLOW_FLAG]  = flag_reg[3];
                rd_data[`ESMB_BIT_MISSED_FRAME_OVERFLOW_MASK] = mask_eff[3];
                rd_data[`ESMB_BIT_RCVCO] = flag_reg[2];
                rd_data[`ESMB_BIT_RCVCOM] = mask_eff[2];
                rd_data[`ESMB_BIT_TXS]   = flag_reg[1];
                rd_data[`ESMB_BIT_TXSM]  = mask_eff[1];
                rd_data[`ESMB_BIT_JAB]   = flag_reg[0];
                rd_data[`ESMB_BIT_JABBER_ERROR_MASK]  = mask_eff[0];
            end
            `ESMB_OFF_CTRL: begin
                rd_data[`ESMB_CTRL_GLOBAL_INTERRUPT_ENABLE] = global_interrupt_enable_reg;
                rd_data[`ESMB_CTRL_STOP] = stop_reg;
                rd_data[`ESMB_CTRL_STYLE_LSB +: `ESMB_CTRL_STYLE_W] = style_reg;
            end
            `ESMB_OFF_IRQ_STAT: rd_data[`ESMB_NUM_EVT-1:0] = irq_stat_reg;
            `ESMB_OFF_IRQ_MASK: rd_data[`ESMB_NUM_EVT-1:0] = irq_mask_reg;
            default:            rd_data = `ESMB_UNMAPPED_DATA;
        endcase
    end

    always_ff @(posedge SYS_CLK) begin
        if (RST) begin
            AVS_READDATA <= '0;
        end else if (access && AVS_READ) begin
            AVS_READDATA <= rd_data;
        end
    end

endmodule : esmb_top

// ### esmb_top_properties.sv
// Purpose: Port-level properties of esmb_top
// Assumes: One clock, RST synchronous active high
// Notes:   Flags are internal, so outputs are tied to causes
`timescale 1ns/1ps
`include "esmb_params.svh"
module esmb_top_chk (
    input wire logic                    SYS_CLK,
    input wire logic                    RST,
    input wire logic [`ESMB_ADDR_W-1:0] AVS_ADDRESS,
    input wire logic                    AVS_READ,
    input wire logic                    AVS_WRITE,
    input wire logic [31:0]             AVS_READDATA,
    input wire logic                    AVS_WAITREQUEST,
    input wire logic                    MISSED_FRAME_WRAP,
    input wire logic                    RX_COLLISION_WRAP,
    input wire logic                    TX_FRAME_START,
    input wire logic                    JABBER_DETECT,
    input wire logic                    INTERRUPT_OUTPUT,
    input wire logic                    BLOCK_IRQ
);
    default clocking cb @(posedge SYS_CLK); endclocking
    default disable iff (RST);
    ////////////////////////////////////////////////////////////////////////////
    a_wait_answer: assert property ((AVS_READ || AVS_WRITE) && AVS_WAITREQUEST
        |=> !AVS_WAITREQUEST) else $error("request not answered");
    a_wait_one: assert property (!AVS_WAITREQUEST |=> AVS_WAITREQUEST)
        else $error("waitrequest low too long");
    a_reset_quiet: assert property ($past(RST) |-> !INTERRUPT_OUTPUT && !BLOCK_IRQ)
        else $error("output active after reset");
    a_irq_cause: assert property ($rose(INTERRUPT_OUTPUT) |-> $past(AVS_WRITE
        || MISSED_FRAME_WRAP || RX_COLLISION_WRAP || TX_FRAME_START || JABBER_DETECT, 2))
        else $error("interrupt rose without cause");
    a_irq_drop: assert property ($fell(INTERRUPT_OUTPUT) |-> $past(AVS_WRITE, 2))
        else $error("interrupt fell without write");
    a_stat_resvd: assert property (AVS_READ && !AVS_WAITREQUEST
        && AVS_ADDRESS == `ESMB_OFF_STATUS |-> AVS_READDATA[7:6] == 2'h0)
        else $error("reserved bits read nonzero");
    a_unmapped_zero: assert property (AVS_READ && !AVS_WAITREQUEST
        && AVS_ADDRESS[1:0] != 2'h0 |-> AVS_READDATA == `ESMB_UNMAPPED_DATA)
        else $error("unmapped read nonzero");
    a_rdata_hold: assert property (!AVS_READ |=> $stable(AVS_READDATA))
        else $error("read data changed without read");
    c_irq: cover property ($rose(INTERRUPT_OUTPUT));
    c_blk: cover property ($rose(BLOCK_IRQ));
    c_wr: cover property (AVS_WRITE && !AVS_WAITREQUEST);
endmodule : esmb_top_chk
////////////////////////////////////////////////////////////////////////////////
bind esmb_top esmb_top_chk u_chk (.SYS_CLK, .RST, .AVS_ADDRESS, .AVS_READ, .AVS_WRITE,
    .AVS_READDATA, .AVS_WAITREQUEST, .MISSED_FRAME_WRAP, .RX_COLLISION_WRAP,
    .TX_FRAME_START, .JABBER_DETECT, .INTERRUPT_OUTPUT, .BLOCK_IRQ);

// ### tb_top.sv
// Purpose: Register-level test of esmb_top
// Assumes: One wait cycle per access, pulse events
// Notes:   Byte enables stay all-on; lanes untested
`timescale 1ns/1ps
`include "esmb_params.svh"
module tb_top;
    logic        clk, rst, rd, wr, tp, wt, irq, blk;
    logic [3:0]  adr, ev;
    logic [31:0] wd, rdat, got;
    int          n_fail, checked, i;
    logic [31:0] fl [4] = '{32'h200, 32'h020, 32'h008, 32'h002};
    ////////////////////////////////////////////////////////////////////////////
    esmb_top dut (.SYS_CLK(clk), .RST(rst), .AVS_ADDRESS(adr), .AVS_READ(rd),
        .AVS_WRITE(wr), .AVS_WRITEDATA(wd), .AVS_BYTEENABLE(4'hF), .AVS_READDATA(rdat),
        .AVS_WAITREQUEST(wt), .MISSED_FRAME_WRAP(ev[3]), .RX_COLLISION_WRAP(ev[2]),
        .TX_FRAME_START(ev[1]), .JABBER_DETECT(ev[0]), .TP_PORT_ACTIVE(tp),
        .INTERRUPT_OUTPUT(irq), .BLOCK_IRQ(blk));
    ////////////////////////////////////////////////////////////////////////////
    task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk);
        adr <= a;
        wd <= d;
        wr <= w;
        rd <= !w;
        do begin
            @(posedge clk);
            n++;
        end while (wt !== 1'b0 && n < 20);
        // An unanswered request counts as a failure, not a silent pass
        if (wt !== 1'b0) begin
            n_fail++;
        end
        got = rdat;
        wr <= 1'b0;
        rd <= 1'b0;
    endtask : bus
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        checked++;
        if (g !== e) begin
            n_fail++;
            $display("wrong value at %0t: got %h expected %h", $time, g, e);
        end
    endtask : chk
    task automatic rdchk(input logic [3:0] a, input logic [31:0] e);
        bus(1'b0, a, 32'h0);
        chk(got, e);
    endtask : rdchk
    task automatic pulse(input int k);
        @(posedge clk);
        ev <= 4'h8 >> k;
        @(posedge clk);
        ev <= 4'h0;
    endtask : pulse
    task automatic test_done;
        $display("comparisons %0d mismatches %0d", checked, n_fail);
        if (n_fail == 0 && checked > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : test_done
    ////////////////////////////////////////////////////////////////////////////
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    initial begin
        repeat (3000) @(posedge clk);
        n_fail++;
        test_done;
    end
    initial begin
        {rst, rd, wr, tp, adr, ev, wd, n_fail, checked} = {4'h9, 8'h0, 32'h0, 64'h0};
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        rdchk(`ESMB_OFF_STATUS, 32'h115);
        bus(1'b1, `ESMB_OFF_CTRL, 32'h1);
        bus(1'b1, `ESMB_OFF_STATUS, 32'hC0);
        rdchk(`ESMB_OFF_STATUS, 32'h0);
        for (i = 0; i < 4; i++) begin
            pulse(i);
            rdchk(`ESMB_OFF_STATUS, fl[i]);
            chk({31'h0, irq}, 32'h1);
            bus(1'b1, `ESMB_OFF_STATUS, 32'h0);
            rdchk(`ESMB_OFF_STATUS, fl[i]);
            bus(1'b1, `ESMB_OFF_STATUS, fl[i]);
            rdchk(`ESMB_OFF_STATUS, 32'h0);
            bus(1'b1, `ESMB_OFF_STATUS, fl[i] >> 1);
            pulse(i);
            rdchk(`ESMB_OFF_STATUS, fl[i] | fl[i] >> 1);
            chk({31'h0, irq}, 32'h0);
            bus(1'b1, `ESMB_OFF_STATUS, fl[i]);
        end
        $display("flag and mask test done");
        rdchk(`ESMB_OFF_IRQ_STAT, 32'hF);
        bus(1'b1, `ESMB_OFF_IRQ_MASK, 32'h2);
        rdchk(`ESMB_OFF_IRQ_MASK, 32'h2);
        chk({31'h0, blk}, 32'h1);
        bus(1'b1, `ESMB_OFF_IRQ_STAT, 32'h2);
        rdchk(`ESMB_OFF_IRQ_STAT, 32'hD);
        chk({31'h0, blk}, 32'h0);
        tp <= 1'b0;
        pulse(3);
        rdchk(`ESMB_OFF_STATUS, 32'h0);
        bus(1'b1, `ESMB_OFF_CTRL, 32'h101);
        tp <= 1'b1;
        pulse(0);
        pulse(1);
        pulse(3);
        bus(1'b1, `ESMB_OFF_STATUS, 32'h100);
        rdchk(`ESMB_OFF_STATUS, 32'h0);
        $display("legacy test done");
        bus(1'b1, `ESMB_OFF_CTRL, 32'h1);
        bus(1'b1, `ESMB_OFF_STATUS, 32'h10);
        pulse(2);
        bus(1'b1, `ESMB_OFF_CTRL, 32'h2);
        rdchk(`ESMB_OFF_STATUS, 32'h10);
        bus(1'b1, `ESMB_OFF_CTRL, 32'h4);
        rdchk(`ESMB_OFF_STATUS, 32'h115);
        bus(1'b1, 4'h6, 32'hFFFF_FFFF);
        rdchk(4'h6, 32'h0);
        rdchk(`ESMB_OFF_STATUS, 32'h115);
        $display("stop and reset test done");
        test_done;
    end
endmodule : tb_top
